// [hw/phy_regs_consts.svh]
// Constants for the PHY basic control and status register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// Management register addresses
`define REGAD_CONTROL        5'h00
`define REGAD_STATUS         5'h01
// Default management PHY addresses of port 1 and port 2
`define PHYAD_PORT1_DEF      5'h01
`define PHYAD_PORT2_DEF      5'h02

// Control word bit positions
`define CB_LOOPBACK          4'hE
`define CB_FORCE_100         4'hD
`define CB_AUTONEG_ON        4'hC
`define CB_POWER_DOWN        4'hB
`define CB_AUTONEG_RESTART   4'h9
`define CB_FORCE_FULL        4'h8
`define CB_XOVER_VARIANT     4'h5
`define CB_STRAIGHT_PINOUT   4'h4
`define CB_XOVER_DETECT_OFF  4'h3
`define CB_FAR_FAULT_OFF     4'h2
`define CB_TX_OFF            4'h1
`define CB_INDICATOR_OFF     4'h0
// Writable bits and reset value of the control word
`define CTRL_WR_MASK         16'h7b3f
`define CTRL_RESET           16'h1020
// Status word: bits 15..12 fixed, lower bits outside this bank
`define STATUS_VALUE         16'h7000

// Switch register numbers (port 1 / port 2)
`define SWREG_GLOBAL_PHYAD   8'h0f
`define SWREG_P1_SPEED       8'h1c
`define SWREG_P1_MISC        8'h1d
`define SWREG_P1_XOVER       8'h1f
`define SWREG_P2_SPEED       8'h2c
`define SWREG_P2_MISC        8'h2d
`define SWREG_P2_XOVER       8'h2f
// PHY address field inside the global register
`define GLB_PHYAD_HI         3'h7
`define GLB_PHYAD_LO         3'h3
`define GLB_RESET            8'h00

// Mirror bit positions inside the switch registers
`define SB_SPEED_AUTONEG     3'h7
`define SB_SPEED_100         3'h6
`define SB_SPEED_FULL        3'h5
`define SB_MISC_INDICATOR    3'h7
`define SB_MISC_TX_OFF       3'h6
`define SB_MISC_RESTART      3'h5
`define SB_MISC_FAR_FAULT    3'h4
`define SB_MISC_POWER_DOWN   3'h3
`define SB_MISC_XOVER_OFF    3'h2
`define SB_MISC_STRAIGHT     3'h1
`define SB_MISC_LOOPBACK     3'h0
`define SB_XOVER_VARIANT     3'h7

// Switch register group selectors
`define SWSEL_SPEED          2'h0
`define SWSEL_MISC           2'h1
`define SWSEL_XOVER          2'h2

`endif

// [hw/phy_regs_pkg.sv]
// Types shared by the PHY basic control and status register bank.
// Assumes phy_regs_consts.svh is on the include path.
`default_nettype none
`include "phy_regs_consts.svh"

package phy_regs_pkg;

  typedef logic [15:0] ctrl_word_t;

  // Top-level state, registered as one word
  typedef struct packed {
    logic        mgmt_ack;
    logic        mgmt_hit;
    logic [15:0] mgmt_rdata;
    logic        sw_ack;
    logic [7:0]  sw_rdata;
    logic [7:0]  glb_phyad;
    logic        phyad_prog;
  } top_state_s;

  // Per-port bank state
  typedef struct packed {
    ctrl_word_t ctrl;
    logic       restart_pulse;
  } bank_state_s;

endpackage

`default_nettype wire

// [hw/ctrl_bank_if.sv]
// Signals between the register decoder and one port's control bank.
// Assumes both ends run on the same clock.
`default_nettype none

interface ctrl_bank_if;
  logic                      mgmt_we;
  logic [15:0]               mgmt_wdata;
  logic                      sw_we;
  logic [1:0]                sw_sel;
  logic [7:0]                sw_wdata;
  phy_regs_pkg::ctrl_word_t  ctrl;
  logic                      restart_pulse;

  modport bank  (input  mgmt_we, mgmt_wdata, sw_we, sw_sel, sw_wdata,
                 output ctrl, restart_pulse);
  modport owner (output mgmt_we, mgmt_wdata, sw_we, sw_sel, sw_wdata,
                 input  ctrl, restart_pulse);
endinterface

`default_nettype wire

// [hw/port_ctrl_bank.sv]
// One port's control word, written by either access path.
// Assumes writes come from logic on i_clk; only one path wins per cycle.
`default_nettype none
`include "phy_regs_consts.svh"

module port_ctrl_bank #(
  parameter bit HAS_FAR_FAULT_MIRROR = 1'b1
) (
  // Clock, reset, enable
  input  wire logic     i_clk,
  input  wire logic     i_nrst,
  input  wire logic     i_ce,
  // Decoder side
  ctrl_bank_if.bank     bus
);

  phy_regs_pkg::bank_state_s st;
  phy_regs_pkg::bank_state_s next_st;
  logic [15:0]               sw_merged;

  ////////////////////////////////////////////////////////////////////////
  // Merge a switch register byte into the shared word
  always_comb begin
    sw_merged = st.ctrl;
    if (bus.sw_sel == `SWSEL_SPEED) begin
      sw_merged[`CB_FORCE_100]  = bus.sw_wdata[`SB_SPEED_100];
      sw_merged[`CB_AUTONEG_ON] = bus.sw_wdata[`SB_SPEED_AUTONEG];
      sw_merged[`CB_FORCE_FULL] = bus.sw_wdata[`SB_SPEED_FULL];
    end else if (bus.sw_sel == `SWSEL_MISC) begin
      sw_merged[`CB_LOOPBACK]   = bus.sw_wdata[`SB_MISC_LOOPBACK];
      sw_merged[`CB_POWER_DOWN] = bus.sw_wdata[`SB_MISC_POWER_DOWN];
      sw_merged[`CB_AUTONEG_RESTART] =
        bus.sw_wdata[`SB_MISC_RESTART];
      sw_merged[`CB_STRAIGHT_PINOUT] =
        bus.sw_wdata[`SB_MISC_STRAIGHT];
      sw_merged[`CB_XOVER_DETECT_OFF] =
        bus.sw_wdata[`SB_MISC_XOVER_OFF];
      if (HAS_FAR_FAULT_MIRROR) begin
        sw_merged[`CB_FAR_FAULT_OFF] =
          bus.sw_wdata[`SB_MISC_FAR_FAULT];
      end
      sw_merged[`CB_TX_OFF]     = bus.sw_wdata[`SB_MISC_TX_OFF];
      sw_merged[`CB_INDICATOR_OFF] =
        bus.sw_wdata[`SB_MISC_INDICATOR];
    end else if (bus.sw_sel == `SWSEL_XOVER) begin
      sw_merged[`CB_XOVER_VARIANT] =
        bus.sw_wdata[`SB_XOVER_VARIANT];
    end
  end

  // Next state: management write wins over a same-cycle switch write
  always_comb begin
    next_st = st;
    next_st.restart_pulse = 1'b0;
    if (bus.mgmt_we) begin
      next_st.ctrl = (bus.mgmt_wdata & `CTRL_WR_MASK)
                   | (st.ctrl & ~`CTRL_WR_MASK);
    end else if (bus.sw_we) begin
      next_st.ctrl = sw_merged;
    end
    // A written 1 on the restart bit kicks one restart pulse
    if ((bus.mgmt_we || bus.sw_we) &&
        next_st.ctrl[`CB_AUTONEG_RESTART]) begin
      next_st.restart_pulse = 1'b1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st.ctrl          <= `CTRL_RESET;
      st.restart_pulse <= 1'b0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign bus.ctrl          = st.ctrl;
  assign bus.restart_pulse = st.restart_pulse;

endmodule

`default_nettype wire

// [hw/phy_basic_control_status_regs.sv]
// Basic control and status registers of the two copper PHY ports.
// Assumes both access ports are driven by logic on i_clk; requests are
// single-cycle strobes and each is answered on the following edge.
`default_nettype none
`include "phy_regs_consts.svh"

// What this block does
// - REGAD 0 control, 1 status; two PHYADs
// - Bit 14 loopback, mirrors misc bit 0
// - Bit 13 forces 100 or 10 Mbps
// - Bit 12 autoneg enable, resets to one
// - Bit 11 powers port down
// - Writing one on bit 9 restarts autoneg
// - Bit 8 forces full or half duplex
// - Bit 5 picks crossover variant, resets one
// - Bit 4 forces straight-through pinout
// - Bit 3 disables automatic crossover detection
// - Bit 2 disables far-end fault, port one mirror
// - Bit 1 disables the port transmitter
// - Bit 0 switches the port indicators off
// - Status bit 15 always reads zero
// - Status bits 14 to 12 read one
// - PHYADs default 1/2, else global field
module phy_basic_control_status_regs (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // Management access (deframed station management transaction)
  input  wire logic        i_mgmt_req,
  input  wire logic        i_mgmt_wr,
  input  wire logic [4:0]  i_mgmt_phy_addr,
  input  wire logic [4:0]  i_mgmt_reg_addr,
  input  wire logic [15:0] i_mgmt_wdata,
  output logic             o_mgmt_ack,
  output logic             o_mgmt_hit,
  output logic [15:0]      o_mgmt_rdata,
  // Switch register access
  input  wire logic        i_sw_req,
  input  wire logic        i_sw_wr,
  input  wire logic [7:0]  i_sw_addr,
  input  wire logic [7:0]  i_sw_wdata,
  output logic             o_sw_ack,
  output logic [7:0]       o_sw_rdata,
  // Per-port controls, index 0 is port 1
  output logic [1:0]       o_loopback,
  output logic [1:0]       o_force_100,
  output logic [1:0]       o_autoneg_on,
  output logic [1:0]       o_power_down,
  output logic [1:0]       o_autoneg_restart,
  output logic [1:0]       o_force_full,
  output logic [1:0]       o_crossover_variant_select,
  output logic [1:0]       o_straight_pinout_force,
  output logic [1:0]       o_crossover_detect_off,
  output logic [1:0]       o_far_fault_off,
  output logic [1:0]       o_tx_off,
  output logic [1:0]       o_indicator_off
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  phy_regs_pkg::top_state_s st;
  phy_regs_pkg::top_state_s next_st;

  ctrl_bank_if bank_bus [2] ();

  logic [1:0][15:0] ctrl;
  logic [1:0]       restart;
  logic [4:0]       phyad_port1;
  logic [4:0]       phyad_port2;
  logic [1:0]       mgmt_port_sel;
  logic             mgmt_reg_ok;
  logic             mgmt_we_any;
  logic [1:0]       sw_port_sel;
  logic [1:0]       sw_sel;
  logic             sw_mirror_hit;
  logic [1:0]       sw_we_port;

  ////////////////////////////////////////////////////////////////////////
  // Management PHY addresses

  // Defaults until software programs the global field, then the
  // field names port 1 and the next address names port 2
  always_comb begin
    if (st.phyad_prog) begin
      phyad_port1 = st.glb_phyad[`GLB_PHYAD_HI:`GLB_PHYAD_LO];
      phyad_port2 = 5'(phyad_port1 + 5'h01);
    end else begin
      phyad_port1 = `PHYAD_PORT1_DEF;
      phyad_port2 = `PHYAD_PORT2_DEF;
    end
  end

  // Which port a management access targets, and is the register ours
  always_comb begin
    mgmt_port_sel = 2'h0;
    if (i_mgmt_phy_addr == phyad_port1) begin
      mgmt_port_sel = 2'h1;
    end else if (i_mgmt_phy_addr == phyad_port2) begin
      mgmt_port_sel = 2'h2;
    end
    mgmt_reg_ok = (i_mgmt_reg_addr == `REGAD_CONTROL) ||
                  (i_mgmt_reg_addr == `REGAD_STATUS);
  end

  // Only a control register write reaches the storage
  assign mgmt_we_any = i_ce && i_mgmt_req && i_mgmt_wr &&
                       (i_mgmt_reg_addr == `REGAD_CONTROL);

  ////////////////////////////////////////////////////////////////////////
  // Switch register decode

  // Map a switch register number to a port and a mirror group
  always_comb begin
    sw_port_sel   = 2'h0;
    sw_sel        = `SWSEL_SPEED;
    sw_mirror_hit = 1'b0;
    if (i_sw_addr == `SWREG_P1_SPEED) begin
      sw_port_sel   = 2'h1;
      sw_mirror_hit = 1'b1;
    end else if (i_sw_addr == `SWREG_P1_MISC) begin
      sw_port_sel   = 2'h1;
      sw_sel        = `SWSEL_MISC;
      sw_mirror_hit = 1'b1;
    end else if (i_sw_addr == `SWREG_P1_XOVER) begin
      sw_port_sel   = 2'h1;
      sw_sel        = `SWSEL_XOVER;
      sw_mirror_hit = 1'b1;
    end else if (i_sw_addr == `SWREG_P2_SPEED) begin
      sw_port_sel   = 2'h2;
      sw_mirror_hit = 1'b1;
    end else if (i_sw_addr == `SWREG_P2_MISC) begin
      sw_port_sel   = 2'h2;
      sw_sel        = `SWSEL_MISC;
      sw_mirror_hit = 1'b1;
    end else if (i_sw_addr == `SWREG_P2_XOVER) begin
      sw_port_sel   = 2'h2;
      sw_sel        = `SWSEL_XOVER;
      sw_mirror_hit = 1'b1;
    end
  end

  assign sw_we_port = (i_ce && i_sw_req && i_sw_wr && sw_mirror_hit) ?
                      sw_port_sel : 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Per-port control banks, one shared word per port

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign bank_bus[p].mgmt_we    = mgmt_we_any && mgmt_port_sel[p];
    assign bank_bus[p].mgmt_wdata = i_mgmt_wdata;
    assign bank_bus[p].sw_we      = sw_we_port[p];
    assign bank_bus[p].sw_sel     = sw_sel;
    assign bank_bus[p].sw_wdata   = i_sw_wdata;
    assign ctrl[p]                = bank_bus[p].ctrl;
    assign restart[p]             = bank_bus[p].restart_pulse;

    // Port 2 has no far-end fault mirror in the switch map
    port_ctrl_bank #(
      .HAS_FAR_FAULT_MIRROR (p == 0)
    ) u_bank (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_ce   (i_ce),
      .bus    (bank_bus[p])
    );

    // Control outputs come straight from the bank flops
    assign o_loopback[p]      = ctrl[p][`CB_LOOPBACK];
    assign o_force_100[p]     = ctrl[p][`CB_FORCE_100];
    assign o_autoneg_on[p]    = ctrl[p][`CB_AUTONEG_ON];
    assign o_power_down[p]    = ctrl[p][`CB_POWER_DOWN];
    assign o_autoneg_restart[p] = restart[p];
    assign o_force_full[p]    = ctrl[p][`CB_FORCE_FULL];
    assign o_crossover_variant_select[p] =
      ctrl[p][`CB_XOVER_VARIANT];
    assign o_straight_pinout_force[p] =
      ctrl[p][`CB_STRAIGHT_PINOUT];
    assign o_crossover_detect_off[p] =
      ctrl[p][`CB_XOVER_DETECT_OFF];
    assign o_far_fault_off[p] = ctrl[p][`CB_FAR_FAULT_OFF];
    assign o_tx_off[p]        = ctrl[p][`CB_TX_OFF];
    assign o_indicator_off[p] = ctrl[p][`CB_INDICATOR_OFF];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and answers

  // Management read: control word, fixed status, zero elsewhere.
  // Loopback is not blocked at 10 Mbps; software must force 100 first.
  always_comb begin
    next_st          = st;
    next_st.mgmt_ack = i_mgmt_req;
    next_st.mgmt_hit = i_mgmt_req && (mgmt_port_sel != 2'h0) &&
                       mgmt_reg_ok;
    next_st.sw_ack   = i_sw_req;
    if (i_mgmt_req && !i_mgmt_wr) begin
      next_st.mgmt_rdata = 16'h0000;
      if (mgmt_port_sel != 2'h0) begin
        if (i_mgmt_reg_addr == `REGAD_CONTROL) begin
          next_st.mgmt_rdata = mgmt_port_sel[0] ?
            (ctrl[0] & `CTRL_WR_MASK) :
            (ctrl[1] & `CTRL_WR_MASK);
        end else if (i_mgmt_reg_addr == `REGAD_STATUS) begin
          next_st.mgmt_rdata = `STATUS_VALUE;
        end
      end
    end
    // Switch side read of the mirror bits and the global register
    if (i_sw_req && !i_sw_wr) begin
      next_st.sw_rdata = 8'h00;
      if (i_sw_addr == `SWREG_GLOBAL_PHYAD) begin
        next_st.sw_rdata = st.glb_phyad;
      end else if (sw_mirror_hit) begin
        next_st.sw_rdata = sw_read_byte(
          sw_port_sel[0] ? ctrl[0] : ctrl[1], sw_sel, sw_port_sel[0]);
      end
    end
    // Writes to the global register move the management addresses
    if (i_sw_req && i_sw_wr && (i_sw_addr == `SWREG_GLOBAL_PHYAD)) begin
      next_st.glb_phyad  = i_sw_wdata;
      next_st.phyad_prog = 1'b1;
    end
  end

  // Gather the mirror bits of one switch register from a control word
  function automatic logic [7:0] sw_read_byte(input logic [15:0] w,
                                              input logic [1:0]  sel,
                                              input logic        port1);
    logic [7:0] b;
    b = 8'h00;
    if (sel == `SWSEL_SPEED) begin
      b[`SB_SPEED_100]     = w[`CB_FORCE_100];
      b[`SB_SPEED_AUTONEG] = w[`CB_AUTONEG_ON];
      b[`SB_SPEED_FULL]    = w[`CB_FORCE_FULL];
    end else if (sel == `SWSEL_MISC) begin
      b[`SB_MISC_LOOPBACK]   = w[`CB_LOOPBACK];
      b[`SB_MISC_POWER_DOWN] = w[`CB_POWER_DOWN];
      b[`SB_MISC_RESTART]    = w[`CB_AUTONEG_RESTART];
      b[`SB_MISC_STRAIGHT]   = w[`CB_STRAIGHT_PINOUT];
      b[`SB_MISC_XOVER_OFF]  = w[`CB_XOVER_DETECT_OFF];
      b[`SB_MISC_FAR_FAULT]  = port1 & w[`CB_FAR_FAULT_OFF];
      b[`SB_MISC_TX_OFF]     = w[`CB_TX_OFF];
      b[`SB_MISC_INDICATOR]  = w[`CB_INDICATOR_OFF];
    end else if (sel == `SWSEL_XOVER) begin
      b[`SB_XOVER_VARIANT]   = w[`CB_XOVER_VARIANT];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while the enable is low

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st.mgmt_ack   <= 1'b0;
      st.mgmt_hit   <= 1'b0;
      st.mgmt_rdata <= 16'h0000;
      st.sw_ack     <= 1'b0;
      st.sw_rdata   <= 8'h00;
      st.glb_phyad  <= `GLB_RESET;
      st.phyad_prog <= 1'b0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_mgmt_ack   = st.mgmt_ack;
  assign o_mgmt_hit   = st.mgmt_hit;
  assign o_mgmt_rdata = st.mgmt_rdata;
  assign o_sw_ack     = st.sw_ack;
  assign o_sw_rdata   = st.sw_rdata;

endmodule

`default_nettype wire

// [verif/phy_regs_monitor.sv]
// Checker for the PHY basic control and status register bank.
// Assumes one clock domain and single-cycle registered answers.
`default_nettype none

module phy_regs_monitor (
  // Clock, reset, enable
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  // Management access
  input wire logic        i_mgmt_req,
  input wire logic        i_mgmt_wr,
  input wire logic [4:0]  i_mgmt_reg_addr,
  input wire logic        o_mgmt_ack,
  input wire logic        o_mgmt_hit,
  input wire logic [15:0] o_mgmt_rdata,
  // Switch access
  input wire logic        i_sw_req,
  input wire logic        i_sw_wr,
  input wire logic [7:0]  i_sw_addr,
  input wire logic [7:0]  i_sw_wdata,
  // Port controls
  input wire logic [1:0]  o_loopback,
  input wire logic [1:0]  o_autoneg_on,
  input wire logic [1:0]  o_power_down,
  input wire logic [1:0]  o_autoneg_restart,
  input wire logic [1:0]  o_crossover_variant_select,
  input wire logic [1:0]  o_tx_off
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Answer timing and decode
  a_ack_follows_req: assert property (
    i_ce && i_mgmt_req |=> o_mgmt_ack) else $error("ack missing");
  a_ack_has_cause: assert property (
    o_mgmt_ack && $past(i_ce) |-> $past(i_mgmt_req))
    else $error("ack without request");
  a_hit_needs_ack: assert property (
    o_mgmt_hit |-> o_mgmt_ack) else $error("hit without ack");
  a_regad_miss: assert property (
    i_ce && i_mgmt_req && i_mgmt_reg_addr > 5'h01 |=> !o_mgmt_hit)
    else $error("hit on unmapped register");

  ////////////////////////////////////////////////////////////////////////////
  // Read values
  a_status_fixed: assert property (
    i_ce && i_mgmt_req && !i_mgmt_wr && i_mgmt_reg_addr == 5'h01
    |=> !o_mgmt_hit || o_mgmt_rdata == 16'h7000)
    else $error("status word wrong");
  a_reserved_zero: assert property (
    i_ce && i_mgmt_req && !i_mgmt_wr && i_mgmt_reg_addr == 5'h00
    |=> !o_mgmt_hit || (o_mgmt_rdata & 16'h84c0) == 16'h0000)
    else $error("reserved control bit set");

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs
  a_reset_defaults: assert property (
    $rose(i_nrst) |-> o_autoneg_on == 2'h3 && o_loopback == 2'h0
    && o_crossover_variant_select == 2'h3)
    else $error("control reset value wrong");
  a_restart_cause: assert property (
    o_autoneg_restart != 2'h0 && $past(i_ce)
    |-> $past(i_mgmt_req && i_mgmt_wr || i_sw_req && i_sw_wr))
    else $error("restart pulse without write");
  a_controls_hold: assert property (
    $past(!(i_mgmt_req && i_mgmt_wr) && !(i_sw_req && i_sw_wr))
    |-> $stable(o_loopback) && $stable(o_power_down))
    else $error("control changed without write");
  a_sw_mirror: assert property (
    i_ce && i_sw_req && i_sw_wr && i_sw_addr == 8'h1d && !i_mgmt_req
    |=> o_loopback[0] == $past(i_sw_wdata[0])
    && o_tx_off[0] == $past(i_sw_wdata[6]))
    else $error("switch mirror not applied");
endmodule

bind phy_basic_control_status_regs phy_regs_monitor phy_regs_monitor_i (
  .i_clk, .i_nrst, .i_ce, .i_mgmt_req, .i_mgmt_wr, .i_mgmt_reg_addr,
  .o_mgmt_ack, .o_mgmt_hit, .o_mgmt_rdata, .i_sw_req, .i_sw_wr,
  .i_sw_addr, .i_sw_wdata, .o_loopback, .o_autoneg_on, .o_power_down,
  .o_autoneg_restart, .o_crossover_variant_select, .o_tx_off);

`default_nettype wire

// [verif/mgmt_station.sv]
// Station management controller model on the deframed access port.
// Assumes the device takes a strobe and answers on the next edge.
`default_nettype none

module mgmt_station (
  // Clock
  input  wire logic        i_clk,
  // Answer from the device
  input  wire logic        i_ack,
  input  wire logic        i_hit,
  input  wire logic [15:0] i_rdata,
  // Request to the device
  output var  logic        o_req,
  output var  logic        o_wr,
  output var  logic [4:0]  o_phy_addr,
  output var  logic [4:0]  o_reg_addr,
  output var  logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_phy_addr = 5'h00;
    o_reg_addr = 5'h00;
    o_wdata = 16'h0000;
  end

  // One strobe, then the answer is taken the cycle after
  task automatic xfer(input logic wr, input logic [4:0] pa, ra,
                      input logic [15:0] wd, output logic ak, ht,
                      output logic [15:0] rd);
    @(posedge i_clk);
    #1;
    o_req = 1'b1;
    o_wr = wr;
    o_phy_addr = pa;
    o_reg_addr = ra;
    o_wdata = wd;
    @(posedge i_clk);
    #1;
    ak = i_ack;
    ht = i_hit;
    rd = i_rdata;
    // Released request, address and data lines never keep the last value; o_wr does
    o_req = 1'b0;
    o_phy_addr = ~pa;
    o_reg_addr = ~ra;
    o_wdata = ~wd;
  endtask
endmodule

`default_nettype wire

// [verif/phy_basic_control_status_regs_bench.sv]
// Testbench of the PHY basic control and status register bank.
// Assumes the station model drives management and the bench the switch.
`default_nettype none

module phy_basic_control_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk, i_nrst, i_ce, i_mgmt_req, i_mgmt_wr;
  logic [4:0]  i_mgmt_phy_addr, i_mgmt_reg_addr;
  logic [15:0] i_mgmt_wdata, o_mgmt_rdata, rd;
  logic        o_mgmt_ack, o_mgmt_hit, i_sw_req, i_sw_wr, o_sw_ack, ht;
  logic [7:0]  i_sw_addr, i_sw_wdata, o_sw_rdata, sr;
  logic [1:0]  o_loopback, o_force_100, o_autoneg_on, o_power_down;
  logic [1:0]  o_autoneg_restart, o_force_full, o_crossover_variant_select;
  logic [1:0]  o_straight_pinout_force, o_crossover_detect_off;
  logic [1:0]  o_far_fault_off, o_tx_off, o_indicator_off;
  int          mismatches, samples_checked;

  phy_basic_control_status_regs phy_basic_control_status_regs_i (
    .i_clk, .i_nrst, .i_ce, .i_mgmt_req, .i_mgmt_wr, .i_mgmt_phy_addr,
    .i_mgmt_reg_addr, .i_mgmt_wdata, .o_mgmt_ack, .o_mgmt_hit,
    .o_mgmt_rdata, .i_sw_req, .i_sw_wr, .i_sw_addr, .i_sw_wdata,
    .o_sw_ack, .o_sw_rdata, .o_loopback, .o_force_100, .o_autoneg_on,
    .o_power_down, .o_autoneg_restart, .o_force_full,
    .o_crossover_variant_select, .o_straight_pinout_force,
    .o_crossover_detect_off, .o_far_fault_off, .o_tx_off,
    .o_indicator_off);

  mgmt_station mgmt_station_i (
    .i_clk, .i_ack(o_mgmt_ack), .i_hit(o_mgmt_hit), .i_rdata(o_mgmt_rdata),
    .o_req(i_mgmt_req), .o_wr(i_mgmt_wr), .o_phy_addr(i_mgmt_phy_addr),
    .o_reg_addr(i_mgmt_reg_addr), .o_wdata(i_mgmt_wdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    repeat (2000) @(posedge i_clk);
    mismatches++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string nm, input logic [23:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic mg(input logic wr, input logic [4:0] pa, ra,
                    input logic [15:0] wd);
    logic ak;
    mgmt_station_i.xfer(wr, pa, ra, wd, ak, ht, rd);
    check("mgmt_ack", 24'(ak), 24'h1);
  endtask

  task automatic sw(input logic wr, input logic [7:0] ad, wd);
    @(posedge i_clk);
    #1;
    i_sw_req = 1'b1;
    i_sw_wr = wr;
    i_sw_addr = ad;
    i_sw_wdata = wd;
    @(posedge i_clk);
    #1;
    check("sw_ack", 24'(o_sw_ack), 24'h1);
    sr = o_sw_rdata;
    i_sw_req = 1'b0;
    i_sw_addr = ~ad;
    i_sw_wdata = ~wd;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  logic [7:0] mir_ad[6] = '{8'h1d, 8'h1c, 8'h1f, 8'h2d, 8'h2c, 8'h2f};
  logic [7:0] mir_ex[6] = '{8'hff, 8'he0, 8'h80, 8'hef, 8'he0, 8'h80};

  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_sw_req = 1'b0;
    i_sw_wr = 1'b0;
    i_sw_addr = 8'h00;
    i_sw_wdata = 8'h00;
    repeat (2) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    for (int p = 1; p <= 2; p++) begin
      mg(1'b0, 5'(p), 5'h00, 16'h0000);
      check("ctrl_reset", 24'(rd), 24'h1020);
      mg(1'b0, 5'(p), 5'h01, 16'h0000);
      check("status", 24'(rd), 24'h7000);
      check("status_hit", 24'(ht), 24'h1);
    end
    $display("test reset_status done");
    mg(1'b1, 5'h01, 5'h00, 16'h2000);
    mg(1'b1, 5'h02, 5'h00, 16'h2000);
    mg(1'b1, 5'h01, 5'h00, 16'hffff);
    check("restart_pulse", 24'(o_autoneg_restart), 24'h1);
    // Enable low freezes the pulse for one more cycle
    i_ce = 1'b0;
    @(posedge i_clk);
    #1;
    check("restart_frozen", 24'(o_autoneg_restart), 24'h1);
    i_ce = 1'b1;
    @(posedge i_clk);
    #1;
    check("restart_end", 24'(o_autoneg_restart), 24'h0);
    mg(1'b1, 5'h02, 5'h00, 16'hfffb);
    mg(1'b0, 5'h01, 5'h00, 16'h0000);
    check("ctrl_p1", 24'(rd), 24'h7b3f);
    mg(1'b0, 5'h02, 5'h00, 16'h0000);
    check("ctrl_p2", 24'(rd), 24'h7b3b);
    check("outs_a", 24'({o_loopback, o_force_100, o_autoneg_on, o_power_down,
      o_force_full, o_crossover_variant_select}), 24'hfff);
    check("outs_b", 24'({o_straight_pinout_force, o_crossover_detect_off,
      o_far_fault_off, o_tx_off, o_indicator_off}), 24'h3df);
    $display("test control_write done");
    for (int i = 0; i < 6; i++) begin
      sw(1'b0, mir_ad[i], 8'h00);
      check("mirror", 24'(sr), 24'(mir_ex[i]));
    end
    sw(1'b1, 8'h1d, 8'h00);
    mg(1'b0, 5'h01, 5'h00, 16'h0000);
    check("ctrl_coherent", 24'(rd), 24'h3120);
    check("loop_after_sw", 24'(o_loopback), 24'h2);
    $display("test mirrors done");
    mg(1'b1, 5'h03, 5'h00, 16'h0000);
    check("phy_miss", 24'(ht), 24'h0);
    mg(1'b0, 5'h01, 5'h02, 16'h0000);
    check("reg_miss", 24'(ht), 24'h0);
    mg(1'b1, 5'h01, 5'h01, 16'h0000);
    mg(1'b0, 5'h01, 5'h01, 16'h0000);
    check("status_ro", 24'(rd), 24'h7000);
    $display("test misses done");
    sw(1'b1, 8'h0f, 8'h28);
    mg(1'b0, 5'h05, 5'h01, 16'h0000);
    check("new_phyad", 24'(ht), 24'h1);
    mg(1'b0, 5'h01, 5'h01, 16'h0000);
    check("old_phyad", 24'(ht), 24'h0);
    mg(1'b0, 5'h06, 5'h00, 16'h0000);
    check("p2_moved", 24'(rd), 24'h7b3b);
    $display("test phyad done");
    // Mid-run reset brings back the defaults and the default addresses
    i_nrst = 1'b0;
    @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    mg(1'b0, 5'h01, 5'h00, 16'h0000);
    check("ctrl_rereset", 24'(rd), 24'h1020);
    check("phyad_default", 24'(ht), 24'h1);
    $display("test rereset done");
    final_report();
  end
endmodule

`default_nettype wire
